// ### rtl/bcf_consts.svh
// Constants for the two-way clocked queue and mailbox block.
// Assumes it is included by the package and the design files by bare name.
`ifndef BCF_CONSTS_SVH
`define BCF_CONSTS_SVH

// ----------------------------------------
// Data path geometry
// ----------------------------------------
`define BCF_WIDTH 36
`define BCF_DEPTH 7'h40
`define BCF_PTR_W 6
`define BCF_CNT_W 7
`define BCF_BYTES 4
`define BCF_BYTE_W 9

// ----------------------------------------
// Preset threshold offsets, chosen by the offset select pair
// ----------------------------------------
`define BCF_OFFSET_0 7'h10
`define BCF_OFFSET_1 7'h0c
`define BCF_OFFSET_2 7'h08
`define BCF_OFFSET_3 7'h04

// ----------------------------------------
// Synchronised pin vector layout, data in the low bits
// ----------------------------------------
`define BCF_PIN_W 42
`define BCF_PIN_PG 36
`define BCF_PIN_MBX 37
`define BCF_PIN_EN 38
`define BCF_PIN_DIR 39
`define BCF_PIN_SELN 40
`define BCF_PIN_CLK 41
`define BCF_PIN_RST 42'h100_0000_0000

// ----------------------------------------
// Register map and reset values
// ----------------------------------------
`define BCF_ADDR_W 6
`define BCF_REG_CTRL 6'h00
`define BCF_REG_STATUS 6'h04
`define BCF_REG_MASK 6'h08
`define BCF_REG_LEVELS 6'h0c
`define BCF_EV_W 6
`define BCF_CTRL_RST 1'b1
`define BCF_MASK_RST 6'h00

`endif

// ### rtl/bcf_pkg.sv
// Types and shared byte-parity helpers for the queue and mailbox block.
// Assumes the constants header is on the include path.
`include "bcf_consts.svh"

package bcf_pkg;

  typedef logic [`BCF_WIDTH-1:0] bcf_word_t;
  typedef logic [`BCF_CNT_W-1:0] bcf_cnt_t;

  // True when any byte fails the selected parity.
  function automatic logic bcf_par_err(input bcf_word_t w, input logic odd);
    logic err;
    err = 1'b0;
    for (int i = 0; i < `BCF_BYTES; i++) begin
      err = err | ((^w[i*`BCF_BYTE_W +: `BCF_BYTE_W]) != odd);
    end
    return err;
  endfunction

  // Replaces the top bit of each byte with parity over its low bits.
  function automatic bcf_word_t bcf_gen_par(input bcf_word_t w, input logic odd);
    bcf_word_t g;
    g = w;
    for (int i = 0; i < `BCF_BYTES; i++) begin
      g[i*`BCF_BYTE_W + `BCF_BYTE_W - 1] = (^w[i*`BCF_BYTE_W +: `BCF_BYTE_W - 1]) ^ odd;
    end
    return g;
  endfunction

  // Flag pair: drops at once when not ok, rises through two port edges.
  function automatic logic [1:0] bcf_release(input logic [1:0] st, input logic ok, input logic tick);
    logic [1:0] n;
    n = st;
    if (!ok) begin
      n = 2'h0;
    end else if (tick) begin
      n = {st[0], 1'b1};
    end
    return n;
  endfunction

endpackage

// ### rtl/bcf_queue.sv
// One 64-word queue with its four status flags.
// Assumes port edge pulses and requests on the system clock, one cycle each.
`timescale 1ns/10ps
`include "bcf_consts.svh"

module bcf_queue (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Port edges and requests
  input wire logic wr_tick_i,
  input wire logic rd_tick_i,
  input wire logic wr_req_i,
  input wire logic rd_req_i,
  input wire bcf_pkg::bcf_word_t wdata_i,
  input wire bcf_pkg::bcf_cnt_t offset_i,
  // Data and flags
  output bcf_pkg::bcf_word_t rdata_o,
  output logic full_n_o,
  output logic near_full_n_o,
  output logic empty_n_o,
  output logic near_empty_n_o
);

  bcf_pkg::bcf_word_t mem_r [0:`BCF_DEPTH-1];
  logic [`BCF_PTR_W-1:0] wp_r;
  logic [`BCF_PTR_W-1:0] rp_r;
  bcf_pkg::bcf_cnt_t cnt_r;
  logic [1:0] fs_r;
  logic [1:0] nf_r;
  logic [1:0] es_r;
  logic [1:0] ne_r;

  // ----------------------------------------
  // Occupancy
  // ----------------------------------------
  // Flags gate transfers.
  wire do_wr = wr_req_i & full_n_o;
  wire do_rd = rd_req_i & empty_n_o;
  wire bcf_pkg::bcf_cnt_t cnt_nxt = cnt_r + bcf_pkg::bcf_cnt_t'(do_wr) - bcf_pkg::bcf_cnt_t'(do_rd);
  wire bcf_pkg::bcf_cnt_t space = `BCF_DEPTH - cnt_nxt;
  wire full_ok = cnt_nxt != `BCF_DEPTH;
  wire near_full_ok = space > offset_i;
  wire empty_ok = cnt_nxt != 7'h00;
  wire near_empty_ok = cnt_nxt > offset_i;

  assign full_n_o = fs_r[1];
  assign near_full_n_o = nf_r[1];
  assign empty_n_o = es_r[1];
  assign near_empty_n_o = ne_r[1];

  always_ff @(posedge clk_i) begin
    if (do_wr) begin
      mem_r[wp_r] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      rdata_o <= '0;
      fs_r <= 2'h0;
      nf_r <= 2'h3;
      es_r <= 2'h0;
      ne_r <= 2'h0;
    end else begin
      if (do_wr) begin
        wp_r <= wp_r + 1'b1;
      end
      if (do_rd) begin
        rdata_o <= mem_r[rp_r];
        rp_r <= rp_r + 1'b1;
      end
      cnt_r <= cnt_nxt;
      fs_r <= bcf_pkg::bcf_release(fs_r, full_ok, wr_tick_i);
      nf_r <= bcf_pkg::bcf_release(nf_r, near_full_ok, wr_tick_i);
      es_r <= bcf_pkg::bcf_release(es_r, empty_ok, rd_tick_i);
      ne_r <= bcf_pkg::bcf_release(ne_r, near_empty_ok, rd_tick_i);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_count_bound : assert property (
    @(posedge clk_i) disable iff (!rst_n_i) cnt_r <= `BCF_DEPTH)
    else $error("queue count above depth");

  a_count_moves : assert property (
    @(posedge clk_i) disable iff (!rst_n_i) (cnt_r != $past(cnt_r)) |-> $past(wr_tick_i || rd_tick_i))
    else $error("queue count moved without a port edge");

  a_empty_rise : assert property (
    @(posedge clk_i) disable iff (!rst_n_i) $rose(empty_n_o) |-> $past(rd_tick_i) && $past(es_r[0]))
    else $error("empty flag rose before second reader edge");

  a_full_rise : assert property (
    @(posedge clk_i) disable iff (!rst_n_i) $rose(full_n_o) |-> $past(wr_tick_i) && $past(fs_r[0]))
    else $error("full flag rose off a writer edge");

  a_near_empty_rise : assert property (
    @(posedge clk_i) disable iff (!rst_n_i) $rose(near_empty_n_o) |-> $past(rd_tick_i))
    else $error("near empty flag rose off a reader edge");

endmodule

// ### rtl/bcf_mailbox_top.sv
// Two-way clocked queue pair with mailboxes, parity and a register slave.
// Assumes port pins are slow against the system clock and sampled by it.
//
// Functional notes
// - Two 64x36 queues, left to right and right to left.
// - Each queue gives empty, full, near-empty and near-full flags.
// - Two 36-bit mailboxes pass words around the queues.
// - Each mailbox has a flag telling the reader new mail arrived.
// - Mail write drops the flag and blocks rewrites; reader read or reset raises it.
// - Input parity is checked and flagged but never blocks a transfer.
// - Each port may select parity generation on read words.
// - Generated parity lands on bits 8, 17, 26 and 35.
// - Transfers happen only on port clock rises with select and enable active.
// - Port clocks may be fully unrelated or coincident.
// - Full and near-full pass two stages on the writer's clock.
// - Empty and near-empty pass two stages on the reader's clock.
// - Reset drives near-empty low, near-full and both mail flags high.
// - Data bus drives only when selected for a read.
// - Mail written meanwhile reaches an active right mailbox read without a right edge.
// - Empty is low after reset, rises on second reader edge after a word.
// - Offset selects are captured as reset ends, picking one of four offsets.
//
// Added by the designer: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "bcf_consts.svh"

module bcf_mailbox_top (
  // System clock and reset
  input wire logic SYS_CLK_I,
  input wire logic RESET_N_I,
  // AHB-Lite register slave
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  output logic [31:0] HRDATA_O,
  output logic IRQ_O,
  // Threshold offset straps
  input wire logic OFFSET_SELECT_LO_I,
  input wire logic OFFSET_SELECT_HI_I,
  // Left port
  input wire logic LEFT_PORT_CLOCK_I,
  input wire logic LEFT_PORT_SELECT_N_I,
  input wire logic LEFT_PORT_DIRECTION_I,
  input wire logic LEFT_PORT_ENABLE_I,
  input wire logic LEFT_MAILBOX_SELECT_I,
  input wire logic LEFT_PARITY_GEN_SELECT_I,
  input wire logic [35:0] LEFT_DATA_I,
  output logic [35:0] LEFT_DATA_O,
  output logic LEFT_DATA_OE_O,
  output logic LEFT_QUEUE_EMPTY_N_O,
  output logic LEFT_QUEUE_FULL_N_O,
  output logic LEFT_NEAR_EMPTY_N_O,
  output logic LEFT_NEAR_FULL_N_O,
  output logic LEFT_PARITY_ERROR_N_O,
  // Right port
  input wire logic RIGHT_PORT_CLOCK_I,
  input wire logic RIGHT_PORT_SELECT_N_I,
  input wire logic RIGHT_PORT_DIRECTION_I,
  input wire logic RIGHT_PORT_ENABLE_I,
  input wire logic RIGHT_MAILBOX_SELECT_I,
  input wire logic RIGHT_PARITY_GEN_SELECT_I,
  input wire logic [35:0] RIGHT_DATA_I,
  output logic [35:0] RIGHT_DATA_O,
  output logic RIGHT_DATA_OE_O,
  output logic RIGHT_QUEUE_EMPTY_N_O,
  output logic RIGHT_QUEUE_FULL_N_O,
  output logic RIGHT_NEAR_EMPTY_N_O,
  output logic RIGHT_NEAR_FULL_N_O,
  output logic RIGHT_PARITY_ERROR_N_O,
  // Mailbox flags
  output logic A_TO_B_MAIL_FLAG_N_O,
  output logic B_TO_A_MAIL_FLAG_N_O
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [`BCF_PIN_W-1:0] l_s1_r, l_s2_r, r_s1_r, r_s2_r;
  logic [1:0] off_s1_r, off_s2_r, off_r;
  logic l_clk_d_r, r_clk_d_r, off_done_r;

  // Each port clock is only sampled, so any phase relation works.
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      l_s1_r <= `BCF_PIN_RST;
      l_s2_r <= `BCF_PIN_RST;
      r_s1_r <= `BCF_PIN_RST;
      r_s2_r <= `BCF_PIN_RST;
      l_clk_d_r <= 1'b0;
      r_clk_d_r <= 1'b0;
    end else begin
      l_s1_r <= {LEFT_PORT_CLOCK_I, LEFT_PORT_SELECT_N_I, LEFT_PORT_DIRECTION_I, LEFT_PORT_ENABLE_I,
                 LEFT_MAILBOX_SELECT_I, LEFT_PARITY_GEN_SELECT_I, LEFT_DATA_I};
      r_s1_r <= {RIGHT_PORT_CLOCK_I, RIGHT_PORT_SELECT_N_I, RIGHT_PORT_DIRECTION_I, RIGHT_PORT_ENABLE_I,
                 RIGHT_MAILBOX_SELECT_I, RIGHT_PARITY_GEN_SELECT_I, RIGHT_DATA_I};
      l_s2_r <= l_s1_r;
      r_s2_r <= r_s1_r;
      l_clk_d_r <= l_s2_r[`BCF_PIN_CLK];
      r_clk_d_r <= r_s2_r[`BCF_PIN_CLK];
    end
  end

  // Strap stages carry no reset, so they already hold the settled straps when reset lifts.
  always_ff @(posedge SYS_CLK_I) begin
    off_s1_r <= {OFFSET_SELECT_HI_I, OFFSET_SELECT_LO_I};
    off_s2_r <= off_s1_r;
  end

  // Straps are taken once, on the first cycle after reset release.
  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      off_done_r <= 1'b0;
      off_r <= 2'h0;
    end else if (!off_done_r) begin
      off_done_r <= 1'b1;
      off_r <= off_s2_r;
    end
  end

  wire bcf_pkg::bcf_cnt_t offset_val = (off_r == 2'h0) ? `BCF_OFFSET_0 : (off_r == 2'h1) ? `BCF_OFFSET_1 :
                                      (off_r == 2'h2) ? `BCF_OFFSET_2 : `BCF_OFFSET_3;

  // ----------------------------------------
  // Port decode
  // ----------------------------------------
  wire l_tick = l_s2_r[`BCF_PIN_CLK] & ~l_clk_d_r;
  wire r_tick = r_s2_r[`BCF_PIN_CLK] & ~r_clk_d_r;
  wire l_mbx = l_s2_r[`BCF_PIN_MBX];
  wire r_mbx = r_s2_r[`BCF_PIN_MBX];
  wire l_pg = l_s2_r[`BCF_PIN_PG];
  wire r_pg = r_s2_r[`BCF_PIN_PG];
  wire bcf_pkg::bcf_word_t l_data = l_s2_r[`BCF_WIDTH-1:0];
  wire bcf_pkg::bcf_word_t r_data = r_s2_r[`BCF_WIDTH-1:0];
  wire l_cs = ~l_s2_r[`BCF_PIN_SELN] & l_s2_r[`BCF_PIN_EN];
  wire r_cs = ~r_s2_r[`BCF_PIN_SELN] & r_s2_r[`BCF_PIN_EN];
  // A transfer needs the port edge with select and enable active.
  wire l_wr = l_tick & l_cs & l_s2_r[`BCF_PIN_DIR];
  wire l_rd = l_tick & l_cs & ~l_s2_r[`BCF_PIN_DIR];
  wire r_wr = r_tick & r_cs & r_s2_r[`BCF_PIN_DIR];
  wire r_rd = r_tick & r_cs & ~r_s2_r[`BCF_PIN_DIR];
  // Drive only while selected with the direction set to read.
  wire l_oe_nxt = ~l_s2_r[`BCF_PIN_SELN] & ~l_s2_r[`BCF_PIN_DIR];
  wire r_oe_nxt = ~r_s2_r[`BCF_PIN_SELN] & ~r_s2_r[`BCF_PIN_DIR];

  // ----------------------------------------
  // Queues
  // ----------------------------------------
  bcf_pkg::bcf_word_t ab_rdata, ba_rdata;
  logic ab_full_n, ab_near_full_n, ab_empty_n, ab_near_empty_n;
  logic ba_full_n, ba_near_full_n, ba_empty_n, ba_near_empty_n;

  bcf_queue u_ab_queue (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RESET_N_I),
    .wr_tick_i(l_tick),
    .rd_tick_i(r_tick),
    .wr_req_i(l_wr & ~l_mbx),
    .rd_req_i(r_rd & ~r_mbx),
    .wdata_i(l_data),
    .offset_i(offset_val),
    .rdata_o(ab_rdata),
    .full_n_o(ab_full_n),
    .near_full_n_o(ab_near_full_n),
    .empty_n_o(ab_empty_n),
    .near_empty_n_o(ab_near_empty_n)
  );

  bcf_queue u_ba_queue (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RESET_N_I),
    .wr_tick_i(r_tick),
    .rd_tick_i(l_tick),
    .wr_req_i(r_wr & ~r_mbx),
    .rd_req_i(l_rd & ~l_mbx),
    .wdata_i(r_data),
    .offset_i(offset_val),
    .rdata_o(ba_rdata),
    .full_n_o(ba_full_n),
    .near_full_n_o(ba_near_full_n),
    .empty_n_o(ba_empty_n),
    .near_empty_n_o(ba_near_empty_n)
  );

  assign LEFT_QUEUE_FULL_N_O = ab_full_n;
  assign LEFT_NEAR_FULL_N_O = ab_near_full_n;
  assign LEFT_QUEUE_EMPTY_N_O = ba_empty_n;
  assign LEFT_NEAR_EMPTY_N_O = ba_near_empty_n;
  assign RIGHT_QUEUE_FULL_N_O = ba_full_n;
  assign RIGHT_NEAR_FULL_N_O = ba_near_full_n;
  assign RIGHT_QUEUE_EMPTY_N_O = ab_empty_n;
  assign RIGHT_NEAR_EMPTY_N_O = ab_near_empty_n;

  // ----------------------------------------
  // Mailboxes, output words and parity
  // ----------------------------------------
  bcf_pkg::bcf_word_t mail_ab_r, mail_ba_r, l_dout_r, r_dout_r;
  logic ab_flag_n_r, ba_flag_n_r, l_oe_r, r_oe_r, l_perr_n_r, r_perr_n_r, ctrl_odd_r;

  // A full mailbox refuses further writes until its reader takes it.
  wire ab_wr = l_wr & l_mbx & ab_flag_n_r;
  wire ba_wr = r_wr & r_mbx & ba_flag_n_r;
  wire ab_rd = r_rd & r_mbx;
  wire ba_rd = l_rd & l_mbx;
  // The mailbox feeds the output register every cycle, not only on edges.
  wire bcf_pkg::bcf_word_t l_raw = l_mbx ? mail_ba_r : ba_rdata;
  wire bcf_pkg::bcf_word_t r_raw = r_mbx ? mail_ab_r : ab_rdata;
  wire bcf_pkg::bcf_word_t l_out = l_pg ? bcf_pkg::bcf_gen_par(l_raw, ctrl_odd_r) : l_raw;
  wire bcf_pkg::bcf_word_t r_out = r_pg ? bcf_pkg::bcf_gen_par(r_raw, ctrl_odd_r) : r_raw;
  // The checker trees are busy generating mailbox parity, so the flag is held high.
  wire l_force = l_cs & ~l_s2_r[`BCF_PIN_DIR] & l_mbx & l_pg;
  wire r_force = r_cs & ~r_s2_r[`BCF_PIN_DIR] & r_mbx & r_pg;
  // Check result only reports; no transfer term reads it.
  wire l_perr_nxt = ~(~l_force & bcf_pkg::bcf_par_err(l_data, ctrl_odd_r));
  wire r_perr_nxt = ~(~r_force & bcf_pkg::bcf_par_err(r_data, ctrl_odd_r));

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      mail_ab_r <= '0;
      mail_ba_r <= '0;
      // Mail flags come out of reset high.
      ab_flag_n_r <= 1'b1;
      ba_flag_n_r <= 1'b1;
      l_dout_r <= '0;
      r_dout_r <= '0;
      l_oe_r <= 1'b0;
      r_oe_r <= 1'b0;
      l_perr_n_r <= 1'b1;
      r_perr_n_r <= 1'b1;
    end else begin
      if (ab_wr) begin
        mail_ab_r <= l_data;
      end
      if (ba_wr) begin
        mail_ba_r <= r_data;
      end
      // New mail drops the flag; a deposit wins over a same-cycle take.
      ab_flag_n_r <= ab_wr ? 1'b0 : (ab_rd ? 1'b1 : ab_flag_n_r);
      ba_flag_n_r <= ba_wr ? 1'b0 : (ba_rd ? 1'b1 : ba_flag_n_r);
      l_dout_r <= l_out;
      r_dout_r <= r_out;
      l_oe_r <= l_oe_nxt;
      r_oe_r <= r_oe_nxt;
      l_perr_n_r <= l_perr_nxt;
      r_perr_n_r <= r_perr_nxt;
    end
  end

  assign A_TO_B_MAIL_FLAG_N_O = ab_flag_n_r;
  assign B_TO_A_MAIL_FLAG_N_O = ba_flag_n_r;
  assign LEFT_DATA_O = l_dout_r;
  assign RIGHT_DATA_O = r_dout_r;
  assign LEFT_DATA_OE_O = l_oe_r;
  assign RIGHT_DATA_OE_O = r_oe_r;
  assign LEFT_PARITY_ERROR_N_O = l_perr_n_r;
  assign RIGHT_PARITY_ERROR_N_O = r_perr_n_r;

  // ----------------------------------------
  // Register slave and interrupt
  // ----------------------------------------
  logic [`BCF_EV_W-1:0] status_r, mask_r;
  logic [`BCF_ADDR_W-1:0] dp_addr_r;
  logic dp_wr_r, irq_r, hready_r, hresp_r;
  logic [31:0] hrdata_r;

  wire ahb_act = HSEL_I & HTRANS_I[1] & HREADY_I;
  wire ahb_rd = ahb_act & ~HWRITE_I;
  wire ahb_hit = HADDR_I[31:`BCF_ADDR_W] == '0;
  wire [`BCF_ADDR_W-1:0] ra = HADDR_I[`BCF_ADDR_W-1:0];
  wire [11:0] levels = {off_r, ba_flag_n_r, ab_flag_n_r, ba_near_empty_n, ba_empty_n, ba_near_full_n, ba_full_n,
                        ab_near_empty_n, ab_empty_n, ab_near_full_n, ab_full_n};
  wire [31:0] rd_mux = !ahb_hit ? 32'h0 : (ra == `BCF_REG_CTRL) ? 32'(ctrl_odd_r) :
                       (ra == `BCF_REG_STATUS) ? 32'(status_r) : (ra == `BCF_REG_MASK) ? 32'(mask_r) :
                       (ra == `BCF_REG_LEVELS) ? 32'(levels) : 32'h0;
  wire rd_status = ahb_rd & ahb_hit & (ra == `BCF_REG_STATUS);
  wire [`BCF_EV_W-1:0] events = {r_wr & ~r_mbx & ~ba_full_n, l_wr & ~l_mbx & ~ab_full_n, ba_wr, ab_wr,
                                 r_perr_n_r & ~r_perr_nxt, l_perr_n_r & ~l_perr_nxt};
  // A new event in the clearing cycle survives the read.
  wire [`BCF_EV_W-1:0] status_nxt = (status_r & ~{`BCF_EV_W{rd_status}}) | events;

  always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= '0;
      hrdata_r <= 32'h0;
      hready_r <= 1'b1;
      hresp_r <= 1'b0;
      ctrl_odd_r <= `BCF_CTRL_RST;
      mask_r <= `BCF_MASK_RST;
      status_r <= '0;
      irq_r <= 1'b0;
    end else begin
      dp_wr_r <= ahb_act & HWRITE_I & ahb_hit;
      dp_addr_r <= ra;
      hready_r <= 1'b1;
      hresp_r <= 1'b0;
      if (ahb_rd) begin
        hrdata_r <= rd_mux;
      end
      if (dp_wr_r && dp_addr_r == `BCF_REG_CTRL) begin
        ctrl_odd_r <= HWDATA_I[0];
      end
      if (dp_wr_r && dp_addr_r == `BCF_REG_MASK) begin
        mask_r <= HWDATA_I[`BCF_EV_W-1:0];
      end
      status_r <= status_nxt;
      irq_r <= |(status_nxt & mask_r);
    end
  end

  assign HRDATA_O = hrdata_r;
  assign HREADYOUT_O = hready_r;
  assign HRESP_O = hresp_r;
  assign IRQ_O = irq_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_oe_read_only : assert property (
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I) LEFT_DATA_OE_O |-> $past(!l_s2_r[`BCF_PIN_SELN] && !l_s2_r[`BCF_PIN_DIR]))
    else $error("left bus driven while not selected for read");

  a_ab_flag_drop : assert property (
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I) ab_wr |=> !A_TO_B_MAIL_FLAG_N_O && mail_ab_r == $past(l_data))
    else $error("mail write did not store word and drop flag");

  a_ab_mail_hold : assert property (
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I) (!ab_flag_n_r && !ab_rd) |=> $stable(mail_ab_r) && !ab_flag_n_r)
    else $error("full mailbox changed before it was read");

  a_ab_bypass : assert property (
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      ab_wr ##1 (r_mbx && !r_pg && r_oe_nxt) |=> RIGHT_DATA_O == $past(mail_ab_r))
    else $error("new mail did not reach the right bus");

  a_par_bits : assert property (
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      (r_pg && r_oe_nxt) |=> !bcf_pkg::bcf_par_err(RIGHT_DATA_O, $past(ctrl_odd_r)))
    else $error("generated parity bits wrong on right bus");

  a_left_perr : assert property (
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I)
      (!l_force && bcf_pkg::bcf_par_err(l_data, ctrl_odd_r)) |=> !LEFT_PARITY_ERROR_N_O)
    else $error("left parity error not reported");

  a_offset_hold : assert property (
    @(posedge SYS_CLK_I) disable iff (!RESET_N_I) off_done_r |=> $stable(off_r) && off_done_r)
    else $error("offset select changed after capture");

endmodule

// ### dv/bcf_port_host.sv
// Far-side port host: free-running port clock, pin driver and bus wire.
// Assumes requests change on the system clock, never at a port clock fall.
`timescale 1ns/10ps
module bcf_port_host #(
  parameter realtime HALF = 210.0,
  parameter realtime OFS = 7.0
) (
  // Request and device side
  input wire logic [40:0] req_i,
  input wire logic [35:0] dut_d_i,
  input wire logic dut_oe_i,
  // Pins
  output logic clk_o,
  output logic [40:0] pin_o,
  output logic [35:0] bus_o
);
  logic [35:0] last;

  initial begin
    clk_o = 1'b0;
    pin_o = 41'h100_0000_0000;
    last = 36'h0;
    #OFS;
    forever #HALF clk_o = ~clk_o;
  end

  always @(negedge clk_o) pin_o <= req_i;
  always @(posedge clk_o) begin
    if (dut_oe_i || (!pin_o[40] && pin_o[39])) begin
      last <= bus_o;
    end
  end

  // released bus inverts.
  // A floating wire must not look like the last word, so it shows the inverse.
  always_comb bus_o = dut_oe_i ? dut_d_i : (!pin_o[40] && pin_o[39]) ? pin_o[35:0] : ~last;
endmodule

// ### dv/tb_bidir_clocked_fifo_mailbox.sv
// Self-checking bench for the queue and mailbox block.
// Assumes two port host models and one AHB-Lite master in this file.
`timescale 1ns/10ps
module tb_bidir_clocked_fifo_mailbox;
  localparam logic [40:0] IDLE = 41'h100_0000_0000;
  logic clk, rst_n, hw, irq, hrdy, ab, ba, hresp;
  logic [1:0] ht, pc, oe, emp, nemp, full, perr, nfull, fs;
  logic [31:0] ha, hwd, hrd, rd;
  logic [40:0] req [2];
  logic [40:0] pin [2];
  logic [35:0] bus [2];
  logic [35:0] dout [2];
  logic [36:0] snap;
  int errors, total_checks;

  bcf_mailbox_top i_dut (
    .SYS_CLK_I(clk), .RESET_N_I(rst_n), .HSEL_I(1'b1), .HADDR_I(ha), .HTRANS_I(ht),
    .HWRITE_I(hw), .HSIZE_I(3'h2), .HWDATA_I(hwd), .HREADY_I(hrdy), .HREADYOUT_O(hrdy),
    .HRESP_O(hresp), .HRDATA_O(hrd), .IRQ_O(irq), .OFFSET_SELECT_LO_I(fs[0]), .OFFSET_SELECT_HI_I(fs[1]),
    .LEFT_PORT_CLOCK_I(pc[0]), .LEFT_PORT_SELECT_N_I(pin[0][40]), .LEFT_PORT_DIRECTION_I(pin[0][39]),
    .LEFT_PORT_ENABLE_I(pin[0][38]), .LEFT_MAILBOX_SELECT_I(pin[0][37]), .LEFT_PARITY_GEN_SELECT_I(pin[0][36]),
    .LEFT_DATA_I(bus[0]), .LEFT_DATA_O(dout[0]), .LEFT_DATA_OE_O(oe[0]), .LEFT_QUEUE_EMPTY_N_O(emp[0]),
    .LEFT_QUEUE_FULL_N_O(full[0]), .LEFT_NEAR_EMPTY_N_O(nemp[0]), .LEFT_NEAR_FULL_N_O(nfull[0]),
    .LEFT_PARITY_ERROR_N_O(perr[0]), .RIGHT_PORT_CLOCK_I(pc[1]), .RIGHT_PORT_SELECT_N_I(pin[1][40]),
    .RIGHT_PORT_DIRECTION_I(pin[1][39]), .RIGHT_PORT_ENABLE_I(pin[1][38]), .RIGHT_MAILBOX_SELECT_I(pin[1][37]),
    .RIGHT_PARITY_GEN_SELECT_I(pin[1][36]), .RIGHT_DATA_I(bus[1]), .RIGHT_DATA_O(dout[1]),
    .RIGHT_DATA_OE_O(oe[1]), .RIGHT_QUEUE_EMPTY_N_O(emp[1]), .RIGHT_QUEUE_FULL_N_O(full[1]),
    .RIGHT_NEAR_EMPTY_N_O(nemp[1]), .RIGHT_NEAR_FULL_N_O(nfull[1]), .RIGHT_PARITY_ERROR_N_O(perr[1]),
    .A_TO_B_MAIL_FLAG_N_O(ab), .B_TO_A_MAIL_FLAG_N_O(ba));
  bcf_port_host #(.HALF(210.0), .OFS(7.0)) i_left (.req_i(req[0]), .dut_d_i(dout[0]),
    .dut_oe_i(oe[0]), .clk_o(pc[0]), .pin_o(pin[0]), .bus_o(bus[0]));
  bcf_port_host #(.HALF(230.0), .OFS(3.0)) i_right (.req_i(req[1]), .dut_d_i(dout[1]),
    .dut_oe_i(oe[1]), .clk_o(pc[1]), .pin_o(pin[1]), .bus_o(bus[1]));

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hrdy !== 1'b1 && n < 50);
    if (n >= 50) begin
      errors++;
      test_done();
    end
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    ht <= 2'h2;
    ha <= a;
    hw <= w;
    rdy();
    ht <= 2'h0;
    hwd <= wd;
    rdy();
    rd = hrd;
    chk(hresp, 1'b0);
  endtask

  task automatic rst_seq(input logic [1:0] s);
    rst_n <= 1'b0;
    fs <= s;
    repeat (42) @(posedge clk);
    chk({hresp, ab, ba, nemp, emp, perr, nfull, full}, 13'h0c3c);
    rst_n <= 1'b1;
    repeat (30) @(posedge clk);
    chk(full, 2'h3);
    ahb(1'b0, 32'h0c, 32'h0);
    chk(rd[11:10], s);
    ahb(1'b0, 32'h00, 32'h0);
    chk(rd[0], 1'b1);
  endtask

  // One port transfer; the snapshot is taken while the pins still stand.
  task automatic port(input int s, input logic [40:0] r);
    @(posedge clk);
    req[s] <= r;
    @(negedge pc[s]);
    @(posedge pc[s]);
    repeat (6) @(posedge clk);
    snap = {oe[s], dout[s]};
    req[s] <= IDLE;
    @(negedge pc[s]);
    repeat (8) @(posedge clk);
  endtask

  function automatic logic [40:0] rq(input logic d, e, m, g, input logic [35:0] x);
    return {1'b0, d, e, m, g, x};
  endfunction

  function automatic logic [35:0] gp(input logic [35:0] w);
    for (int i = 0; i < 4; i++) begin
      w[9*i+8] = ~^w[9*i +: 8];
    end
    return w;
  endfunction

  // ----
  // Sequence
  // ----
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    errors = 0;
    total_checks = 0;
    {ht, ha, hw, hwd} = '0;
    req[0] = IDLE;
    req[1] = IDLE;
    rst_seq(2'h1);
    ahb(1'b0, 32'h10, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b1, 32'h08, 32'h4);
    ahb(1'b0, 32'h04, 32'h0);
    ahb(1'b0, 32'h08, 32'h0);
    chk({irq, rd}, 33'h4);
    req[0] <= rq(1'b1, 1'b0, 1'b0, 1'b0, 36'h0);
    repeat (15) @(posedge clk);
    chk(perr[0], 1'b0);
    req[0] <= rq(1'b1, 1'b0, 1'b0, 1'b0, 36'h8_0402_0100);
    repeat (15) @(posedge clk);
    chk(perr[0], 1'b1);
    req[0] <= IDLE;
    repeat (30) @(posedge clk);
    chk(emp[1], 1'b0);
    for (int i = 0; i < 3; i++) begin
      port(0, rq(1'b1, 1'b1, 1'b0, 1'b0, 36'h1_2345_6789 + 36'(i)));
    end
    repeat (30) @(posedge clk);
    chk({emp[1], nemp[1]}, 2'h2);
    for (int i = 0; i < 3; i++) begin
      port(1, rq(1'b0, 1'b1, 1'b0, 1'b0, 36'h0));
      chk(snap, {1'b1, 36'h1_2345_6789 + 36'(i)});
    end
    chk({oe[1], emp[1]}, 2'h0);
    port(0, rq(1'b1, 1'b1, 1'b1, 1'b0, 36'h3_00aa_55ff));
    chk({ab, irq}, 2'h1);
    port(0, rq(1'b1, 1'b1, 1'b1, 1'b0, 36'h0));
    port(1, rq(1'b0, 1'b1, 1'b1, 1'b1, 36'h0));
    chk(snap, {1'b1, gp(36'h3_00aa_55ff)});
    chk(ab, 1'b1);
    ahb(1'b0, 32'h04, 32'h0);
    chk(rd[2], 1'b1);
    ahb(1'b0, 32'h08, 32'h0);
    chk(irq, 1'b0);
    req[1] <= rq(1'b0, 1'b0, 1'b1, 1'b0, 36'h0);
    repeat (15) @(posedge clk);
    port(0, rq(1'b1, 1'b1, 1'b1, 1'b0, 36'h5_a5a5_a5a5));
    chk({oe[1], dout[1], ab}, {1'b1, 36'h5_a5a5_a5a5, 1'b0});
    port(1, rq(1'b1, 1'b1, 1'b1, 1'b0, 36'h6_1234_5678));
    chk(ba, 1'b0);
    port(0, rq(1'b0, 1'b1, 1'b1, 1'b0, 36'h0));
    chk({ba, snap}, {2'h3, 36'h6_1234_5678});
    ahb(1'b1, 32'h00, 32'h0);
    ahb(1'b0, 32'h00, 32'h0);
    chk(rd[0], 1'b0);
    req[0] <= rq(1'b1, 1'b0, 1'b0, 1'b0, 36'h0);
    repeat (15) @(posedge clk);
    chk(perr[0], 1'b1);
    req[0] <= IDLE;
    rst_seq(2'h2);
    test_done();
  end
endmodule
